// *** rtl/dsc_byte_lanes.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsc_byte_lanes #(
  parameter int WIDTH = 32
) (
  input wire logic [WIDTH-1:0] old_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] be_i,
  output logic [WIDTH-1:0] new_o
);
  // ==========================================================
  // Byte lane merge.
  always_comb begin
    for (int i = 0; i < WIDTH / 8; i++) begin
      new_o[i*8 +: 8] = be_i[i] ? wdata_i[i*8 +: 8] : old_i[i*8 +: 8];
    end
  end
endmodule : dsc_byte_lanes
`default_nettype wire

// *** rtl/dsc_consts.svh ***
// How it works
// - Every register is at most 8 bits wide, in byte 0, and byte, halfword and word accesses all work.
// - Byte enable 0 gates the byte that holds each register; a write with it clear leaves the register as is.
// - Protectable registers ignore writes while the write guard input is high.
// - The write-only service control register sits at offset 0x0000 and resets to 0x00.
// - A one in the erase bit launches a full chip erase while the unit is idle and a zero does nothing.
// - When idle, a one in the self-test bit starts the memory self-test unless the erase bit is set, and one in the CRC bit the CRC if neither is.
// - A one in the soft reset bit returns the whole unit, except the avs_readdata_o read data and the bus handshake, to its reset state.
// - A finished operation sets a done flag that stays set until a one is written to it.
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH
`define DSC_ADDR_W 13
`define DSC_OFS_CTRL 13'h0000
`define DSC_OFS_STATUS 13'h0010
`define DSC_OFS_MASK 13'h0014
`define DSC_OFS_STATE 13'h0018
`define DSC_OFS_MEMORY_TYPE_INFO 13'h1FCC
`define DSC_OFS_PERIPHERAL_IDENT_4 13'h1FD0
`define DSC_OFS_PERIPHERAL_IDENT_0 13'h1FE0
`define DSC_OFS_PERIPHERAL_IDENT_1 13'h1FE4
`define DSC_OFS_PERIPHERAL_IDENT_2 13'h1FE8
`define DSC_OFS_PERIPHERAL_IDENT_3 13'h1FEC
`define DSC_OFS_COMPONENT_IDENT_0 13'h1FF0
`define DSC_OFS_COMPONENT_IDENT_1 13'h1FF4
`define DSC_OFS_COMPONENT_IDENT_2 13'h1FF8
`define DSC_OFS_COMPONENT_IDENT_3 13'h1FFC
`define DSC_CTRL_W 8
`define DSC_CTRL_RESET 8'h00
`define DSC_CTRL_ERASE 4
`define DSC_CTRL_SELFTEST 3
`define DSC_CTRL_CRC 2
`define DSC_CTRL_SRST 0
`define DSC_STAT_W 3
`define DSC_STAT_RESET 3'h0
`define DSC_MASK_RESET 3'h0
`define DSC_STAT_DONE 0
`define DSC_STAT_FAIL 1
`define DSC_STAT_PERR 2
`endif

// *** rtl/dsc_op_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsc_op_engine (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic erase_cmd_i,
  input wire logic selftest_cmd_i,
  input wire logic crc_cmd_i,
  input wire logic op_done_i,
  input wire logic op_fail_i,
  output logic erase_start_o,
  output logic selftest_start_o,
  output logic crc_start_o,
  output logic busy_o,
  output dsc_pkg::dsc_op_t op_o,
  output logic done_o,
  output logic fail_o
);
  import dsc_pkg::*;

  dsc_state_t state_q;
  dsc_op_t op_q;
  logic any_cmd;

  // ==========================================================
  // Launch and completion.
  assign any_cmd = erase_cmd_i | selftest_cmd_i | crc_cmd_i;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= DSC_IDLE;
      op_q <= DSC_OP_NONE;
    end else begin
      case (state_q)
        DSC_IDLE: begin
          if (any_cmd) begin
            state_q <= DSC_RUN;
            if (erase_cmd_i) begin
              op_q <= DSC_OP_ERASE;
            end else if (selftest_cmd_i) begin
              op_q <= DSC_OP_SELFTEST;
            end else begin
              op_q <= DSC_OP_CRC;
            end
          end
        end
        DSC_RUN: begin
          if (op_done_i) begin
            state_q <= DSC_IDLE;
            op_q <= DSC_OP_NONE;
          end
        end
        default: begin
          state_q <= DSC_IDLE;
          op_q <= DSC_OP_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      erase_start_o <= 1'b0;
      selftest_start_o <= 1'b0;
      crc_start_o <= 1'b0;
    end else begin
      erase_start_o <= (state_q == DSC_IDLE) & erase_cmd_i;
      selftest_start_o <= (state_q == DSC_IDLE) & ~erase_cmd_i & selftest_cmd_i;
      crc_start_o <= (state_q == DSC_IDLE) & ~erase_cmd_i & ~selftest_cmd_i & crc_cmd_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      done_o <= 1'b0;
      fail_o <= 1'b0;
    end else begin
      done_o <= (state_q == DSC_RUN) & op_done_i;
      fail_o <= ((state_q == DSC_RUN) & op_done_i & op_fail_i) | ((state_q == DSC_RUN) & any_cmd);
    end
  end

  assign busy_o = (state_q == DSC_RUN);
  assign op_o = op_q;
endmodule : dsc_op_engine
`default_nettype wire

// *** rtl/dsc_pkg.sv ***
package dsc_pkg;
  typedef enum logic [1:0] {DSC_OP_NONE, DSC_OP_ERASE, DSC_OP_SELFTEST, DSC_OP_CRC} dsc_op_t;
  typedef enum logic {DSC_IDLE, DSC_RUN} dsc_state_t;
endpackage : dsc_pkg

// *** rtl/dsc_top.sv ***
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dsc_consts.svh"
module dsc_top #(
  parameter logic SYS_MEM_PRESENT = 1'b1,
  // Identification values below are arbitrary.
  parameter logic [3:0] ID_BLOCK_COUNT = 4'h0,
  parameter logic [3:0] VENDOR_CONT_CODE = 4'h0,
  parameter logic [11:0] PART_NUMBER = 12'h123,
  parameter logic [6:0] VENDOR_ID = 7'h2A,
  parameter logic VENDOR_ID_USED = 1'b1,
  parameter logic [3:0] REVISION = 4'h1,
  parameter logic [3:0] REVISION_MINOR = 4'h0,
  parameter logic [3:0] CUSTOMER_MODIFIED = 4'h0,
  parameter logic [3:0] COMPONENT_CLASS = 4'h1,
  parameter logic [3:0] PREAMBLE_NIBBLE = 4'h0,
  parameter logic [7:0] PREAMBLE_BYTE_0 = 8'h0D,
  parameter logic [7:0] PREAMBLE_BYTE_2 = 8'h05,
  parameter logic [7:0] PREAMBLE_BYTE_3 = 8'hB1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [12:0] avs_address_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic periph_write_guard_i,
  input wire logic op_done_i,
  input wire logic op_fail_i,
  output logic erase_start_o,
  output logic mem_selftest_start_o,
  output logic crc_start_o,
  output logic busy_o,
  output logic irq_o
);
  import dsc_pkg::*;

  // ==========================================================
  // Declarations.
  logic ack_q;
  logic [31:0] rdata_q;
  logic req;
  logic wr_en;
  logic wr_blocked;
  logic wr_ok;
  logic srst_q;
  logic unit_rst;
  logic [`DSC_CTRL_W-1:0] ctrl_new;
  logic [`DSC_CTRL_W-1:0] ctrl_cmd;
  logic [`DSC_STAT_W-1:0] status_q;
  logic [`DSC_STAT_W-1:0] status_d;
  logic [`DSC_STAT_W-1:0] status_set;
  logic [`DSC_STAT_W-1:0] status_clr;
  logic [`DSC_STAT_W-1:0] status_wr;
  logic [`DSC_STAT_W-1:0] mask_q;
  logic [`DSC_STAT_W-1:0] mask_new;
  logic [7-`DSC_STAT_W:0] mask_unused;
  logic [7:0] mask_wide;
  logic [7:0] status_wide;
  logic [7:0] clr_wide;
  logic eng_done;
  logic eng_fail;
  logic eng_busy;
  dsc_op_t eng_op;
  logic perr_ev;

  // ==========================================================
  // Address helpers.
  function automatic logic hit(input logic [12:0] addr, input logic [12:0] ofs);
    hit = (addr[12:2] == ofs[12:2]);
  endfunction : hit

  function automatic logic protectable(input logic [12:0] addr);
    protectable = hit(addr, `DSC_OFS_CTRL) | hit(addr, `DSC_OFS_STATUS) |
                  hit(addr, `DSC_OFS_MASK);
  endfunction : protectable

  function automatic logic [31:0] pad8(input logic [7:0] v);
    pad8 = {24'h000000, v};
  endfunction : pad8

  // ==========================================================
  // Avalon-MM handshake.
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign wr_en = avs_write_i & ack_q;
  assign wr_blocked = wr_en & periph_write_guard_i & protectable(avs_address_i);
  assign wr_ok = wr_en & ~wr_blocked;
  assign perr_ev = wr_blocked;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ==========================================================
  // Read data.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_q <= 32'h00000000;
    end else if (avs_read_i & ~ack_q) begin
      rdata_q <= 32'h00000000;
      case (avs_address_i[12:2])
        `DSC_OFS_CTRL >> 2: begin
          rdata_q <= 32'h00000000;
        end
        `DSC_OFS_STATUS >> 2: begin
          rdata_q <= pad8(status_wide);
        end
        `DSC_OFS_MASK >> 2: begin
          rdata_q <= pad8(mask_wide);
        end
        `DSC_OFS_STATE >> 2: begin
          rdata_q <= {29'h00000000, eng_op, eng_busy};
        end
        `DSC_OFS_MEMORY_TYPE_INFO >> 2: begin
          rdata_q <= {31'h00000000, SYS_MEM_PRESENT};
        end
        `DSC_OFS_PERIPHERAL_IDENT_4 >> 2: begin
          rdata_q <= pad8({ID_BLOCK_COUNT, VENDOR_CONT_CODE});
        end
        `DSC_OFS_PERIPHERAL_IDENT_0 >> 2: begin
          rdata_q <= pad8(PART_NUMBER[7:0]);
        end
        `DSC_OFS_PERIPHERAL_IDENT_1 >> 2: begin
          rdata_q <= pad8({VENDOR_ID[3:0], PART_NUMBER[11:8]});
        end
        `DSC_OFS_PERIPHERAL_IDENT_2 >> 2: begin
          rdata_q <= pad8({REVISION, VENDOR_ID_USED, VENDOR_ID[6:4]});
        end
        `DSC_OFS_PERIPHERAL_IDENT_3 >> 2: begin
          rdata_q <= pad8({REVISION_MINOR, CUSTOMER_MODIFIED});
        end
        `DSC_OFS_COMPONENT_IDENT_0 >> 2: begin
          rdata_q <= pad8(PREAMBLE_BYTE_0);
        end
        `DSC_OFS_COMPONENT_IDENT_1 >> 2: begin
          rdata_q <= pad8({COMPONENT_CLASS, PREAMBLE_NIBBLE});
        end
        `DSC_OFS_COMPONENT_IDENT_2 >> 2: begin
          rdata_q <= pad8(PREAMBLE_BYTE_2);
        end
        `DSC_OFS_COMPONENT_IDENT_3 >> 2: begin
          rdata_q <= pad8(PREAMBLE_BYTE_3);
        end
        default: begin
          rdata_q <= 32'h00000000;
        end
      endcase
    end
  end

  assign avs_readdata_o = rdata_q;

  // ==========================================================
  // Service control register.
  dsc_byte_lanes #(
    .WIDTH(`DSC_CTRL_W)
  ) u_ctrl_lanes (
    .old_i(`DSC_CTRL_RESET),
    .wdata_i(avs_writedata_i),
    .be_i(avs_byteenable_i),
    .new_o(ctrl_new)
  );

  assign ctrl_cmd = (wr_ok & hit(avs_address_i, `DSC_OFS_CTRL)) ? ctrl_new : `DSC_CTRL_RESET;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= ctrl_cmd[`DSC_CTRL_SRST];
    end
  end

  assign unit_rst = reset_i | srst_q;

  // ==========================================================
  // Operation engine.
  dsc_op_engine u_engine (
    .clk_i(clk_i),
    .reset_i(unit_rst),
    .erase_cmd_i(ctrl_cmd[`DSC_CTRL_ERASE]),
    .selftest_cmd_i(ctrl_cmd[`DSC_CTRL_SELFTEST]),
    .crc_cmd_i(ctrl_cmd[`DSC_CTRL_CRC]),
    .op_done_i(op_done_i),
    .op_fail_i(op_fail_i),
    .erase_start_o(erase_start_o),
    .selftest_start_o(mem_selftest_start_o),
    .crc_start_o(crc_start_o),
    .busy_o(eng_busy),
    .op_o(eng_op),
    .done_o(eng_done),
    .fail_o(eng_fail)
  );

  assign busy_o = eng_busy;

  // ==========================================================
  // Status, mask and interrupt.
  assign status_wide = {{(8 - `DSC_STAT_W){1'b0}}, status_q};
  assign mask_wide = {{(8 - `DSC_STAT_W){1'b0}}, mask_q};

  dsc_byte_lanes #(
    .WIDTH(8)
  ) u_clr_lanes (
    .old_i(8'h00),
    .wdata_i(avs_writedata_i),
    .be_i(avs_byteenable_i),
    .new_o(clr_wide)
  );

  assign status_wr = clr_wide[`DSC_STAT_W-1:0];
  assign status_clr = (wr_ok & hit(avs_address_i, `DSC_OFS_STATUS)) ? status_wr : `DSC_STAT_RESET;

  always_comb begin
    status_set = `DSC_STAT_RESET;
    status_set[`DSC_STAT_DONE] = eng_done;
    status_set[`DSC_STAT_FAIL] = eng_fail;
    status_set[`DSC_STAT_PERR] = perr_ev;
    status_d = (status_q & ~status_clr) | status_set;
  end

  always_ff @(posedge clk_i) begin
    if (unit_rst) begin
      status_q <= `DSC_STAT_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  dsc_byte_lanes #(
    .WIDTH(8)
  ) u_mask_lanes (
    .old_i(mask_wide),
    .wdata_i(avs_writedata_i),
    .be_i(avs_byteenable_i),
    .new_o({mask_unused, mask_new})
  );

  always_ff @(posedge clk_i) begin
    if (unit_rst) begin
      mask_q <= `DSC_MASK_RESET;
    end else if (wr_ok & hit(avs_address_i, `DSC_OFS_MASK)) begin
      mask_q <= mask_new;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_d & mask_q) & ~srst_q;
    end
  end
endmodule : dsc_top
`default_nettype wire

// *** tb/dsc_engine_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========
// Service engine
module dsc_engine_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic slow_i,
  input wire logic fail_i,
  output logic done_o,
  output logic fail_o
);
  int cnt_q;
  logic tog_q;
  always_ff @(posedge clk_i) begin
    if (reset_i || start_i) begin
      cnt_q <= reset_i ? 0 : (slow_i ? 12 : 1);
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  always_ff @(posedge clk_i) begin
    tog_q <= reset_i ? 1'b0 : !tog_q;
  end
  assign done_o = cnt_q == 1;
  assign fail_o = done_o ? fail_i : tog_q;
endmodule : dsc_engine_model
`default_nettype wire

// *** tb/dsc_top_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========
// Checker
module dsc_top_props (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [12:0] avs_address_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic periph_write_guard_i,
  input wire logic erase_start_o,
  input wire logic mem_selftest_start_o,
  input wire logic crc_start_o,
  input wire logic busy_o,
  input wire logic irq_o
);
  logic ca;
  logic cw;
  logic go;
  logic st;
  logic [2:0] c;
  assign ca = avs_address_i[12:2] == 11'h000;
  assign cw = avs_write_i && !avs_waitrequest_o && ca && avs_byteenable_i[0];
  assign go = cw && !periph_write_guard_i && !busy_o;
  assign st = erase_start_o || mem_selftest_start_o || crc_start_o;
  assign c = avs_writedata_i[4:2];
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("wait state count wrong");
  chk_erase_go: assert property (go && c[2] |=> erase_start_o && busy_o && !crc_start_o)
    else $error("erase not launched");
  chk_test_go: assert property (go && c == 3'h2 |=> mem_selftest_start_o && !erase_start_o)
    else $error("self-test not launched");
  chk_crc_go: assert property (go && c == 3'h1 |=> crc_start_o && busy_o)
    else $error("crc not launched");
  chk_zero_idle: assert property (cw && c == 3'h0 |=> !st)
    else $error("zero write launched an operation");
  chk_guard_drop: assert property (cw && periph_write_guard_i |=> !st)
    else $error("guarded write launched an operation");
  chk_srst_quiet: assert property (cw && avs_writedata_i[0] && !periph_write_guard_i
    |=> ##1 !irq_o && !busy_o) else $error("soft reset did not clear");
  chk_ctrl_zero: assert property (avs_read_i && !avs_waitrequest_o && ca
    |-> avs_readdata_o == 32'h0000_0000) else $error("control reads nonzero");
endmodule : dsc_top_props
bind dsc_top dsc_top_props i_dsc_top_props (.clk_i(clk_i), .reset_i(reset_i),
  .avs_address_i(avs_address_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .periph_write_guard_i(periph_write_guard_i), .erase_start_o(erase_start_o),
  .mem_selftest_start_o(mem_selftest_start_o), .crc_start_o(crc_start_o),
  .busy_o(busy_o), .irq_o(irq_o));
`default_nettype wire

// *** tb/dsc_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========
// Bench top
module dsc_top_tb;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [12:0] avs_address_i = 13'h0000;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic periph_write_guard_i = 1'b0;
  logic slow_q = 1'b0;
  logic fail_q = 1'b0;
  logic [31:0] avs_readdata_o, rdat;
  logic avs_waitrequest_o, op_done_i, op_fail_i, erase_start_o, mem_selftest_start_o;
  logic crc_start_o, busy_o, irq_o;
  logic [2:0] sts = 3'h0;
  logic [2:0] msk = 3'h0;
  logic [15:0] rnd = 16'h0057;
  logic [31:0] idv [10] = '{32'h1, 32'h0, 32'h23, 32'hA1, 32'h1A, 32'h0, 32'hD, 32'h10,
    32'h5, 32'hB1};
  int got[3] = '{0, 0, 0};
  int want[3] = '{0, 0, 0};
  int total_checks = 0;
  int mismatches = 0;
  always #2.5 clk_i = ~clk_i;
  dsc_top i_dsc_top (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .periph_write_guard_i(periph_write_guard_i),
    .op_done_i(op_done_i), .op_fail_i(op_fail_i), .erase_start_o(erase_start_o),
    .mem_selftest_start_o(mem_selftest_start_o), .crc_start_o(crc_start_o),
    .busy_o(busy_o), .irq_o(irq_o));
  dsc_engine_model i_dsc_engine_model (.clk_i(clk_i), .reset_i(reset_i),
    .start_i(erase_start_o | mem_selftest_start_o | crc_start_o), .slow_i(slow_q),
    .fail_i(fail_q), .done_o(op_done_i), .fail_o(op_fail_i));
  always @(posedge clk_i) begin
    got[0] += int'(crc_start_o);
    got[1] += int'(mem_selftest_start_o);
    got[2] += int'(erase_start_o);
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  task automatic bus(input logic w, input logic [12:0] a, input logic [31:0] d,
    input logic [3:0] be);
    @(posedge clk_i);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rdat = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus
  task automatic wr(input logic [12:0] a, input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, a, d, be);
    if (periph_write_guard_i) sts = sts | 3'h4;
    else if (a == 13'h0010 && be[0]) sts = sts & ~d[2:0];
    else if (a == 13'h0014 && be[0]) msk = d[2:0];
  endtask : wr
  task automatic rc(input logic [12:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(rdat, exp);
  endtask : rc
  task automatic irq_chk();
    repeat (2) @(negedge clk_i);
    chk({31'h0, irq_o}, {31'h0, |(sts & msk)});
  endtask : irq_chk
  task automatic cmd(input logic [7:0] v, input int k, input logic slow, input logic fail);
    slow_q <= slow;
    fail_q <= fail;
    wr(13'h0000, {24'h0, v}, 4'h1);
    want[k]++;
    @(negedge clk_i);
    chk({31'h0, busy_o}, 32'h1);
    if (slow) begin
      rc(13'h0018, 32'((3 - k) * 2 + 1));
      wr(13'h0000, 32'h4, 4'h1);
      sts = sts | 3'h2;
    end
    repeat (40) if (busy_o) @(negedge clk_i);
    sts = sts | (fail ? 3'h3 : 3'h1);
    rc(13'h0010, {29'h0, sts});
    irq_chk();
  endtask : cmd
  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    rc(13'h0000, 32'h0);
    rc(13'h0014, 32'h0);
    rc(13'h0100, 32'h0);
    for (int i = 0; i < 10; i++) begin
      rnd = nxt(rnd);
      wr(13'(i < 2 ? 32'h1FCC + 4 * i : 32'h1FD8 + 4 * i), {rnd, rnd}, 4'hF);
      rc(13'(i < 2 ? 32'h1FCC + 4 * i : 32'h1FD8 + 4 * i), idv[i]);
    end
    wr(13'h0014, 32'h0000_0007, 4'hE);
    rc(13'h0014, {29'h0, msk});
    wr(13'h0014, 32'hFFFF_FF01, 4'h1);
    rc(13'h0014, {29'h0, msk});
    for (int b = 2; b < 5; b++) begin
      rnd = nxt(rnd);
      cmd(8'(1 << b), b - 2, rnd[0], rnd[1]);
    end
    cmd(8'h1C, 2, 1'b1, rnd[2]);
    wr(13'h0000, 32'h0, 4'h1);
    wr(13'h0014, 32'h0, 4'h1);
    irq_chk();
    wr(13'h0014, 32'h7, 4'h1);
    irq_chk();
    wr(13'h0010, 32'h7, 4'h1);
    irq_chk();
    @(posedge clk_i);
    periph_write_guard_i <= 1'b1;
    wr(13'h0000, 32'h10, 4'h1);
    wr(13'h0014, 32'h0, 4'h1);
    periph_write_guard_i <= 1'b0;
    rc(13'h0014, {29'h0, msk});
    rc(13'h0010, {29'h0, sts});
    wr(13'h0000, 32'h1, 4'h1);
    sts = 3'h0;
    msk = 3'h0;
    irq_chk();
    rc(13'h0014, 32'h0);
    rc(13'h0010, 32'h0);
    for (int k = 0; k < 3; k++) chk(32'(got[k]), 32'(want[k]));
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    summarize();
  end
endmodule : dsc_top_tb
`default_nettype wire
